//--- msds_pkg.sv
/*
 Shared constants for the motion data set start logic: parameter addresses,
 reset values, start condition codes and control/status bit positions.
 Assumes nothing of its surroundings.
*/
package msds_pkg;
   localparam int MSDS_SET_W = 7;
   localparam int MSDS_NUM_SETS = 128;
   localparam logic [15:0] MSDS_ADDR_COND = 16'h2d10;
   localparam logic [15:0] MSDS_ADDR_RESEL = 16'h2d12;
   localparam logic [15:0] MSDS_ADDR_FALL = 16'h2d18;
   localparam logic [1:0] MSDS_COND_RST = 2'h0;
   localparam logic MSDS_RESEL_RST = 1'b0;
   localparam logic MSDS_FALL_RST = 1'b0;
   localparam logic [1:0] MSDS_COND_RISE = 2'h0;
   localparam logic [1:0] MSDS_COND_FALL = 2'h1;
   localparam logic [1:0] MSDS_COND_HIGH = 2'h2;
   localparam logic [1:0] MSDS_COND_LOW = 2'h3;
   localparam logic MSDS_RESEL_CONFIRM = 1'b0;
   localparam logic MSDS_RESEL_AUTO = 1'b1;
   localparam logic MSDS_FALL_CANCEL = 1'b1;
   localparam int MSDS_CTRL_START_BIT = 4;
   localparam int MSDS_CTRL_SEQ_BIT = 5;
   localparam int MSDS_STAT_SEQ_END_BIT = 10;
   localparam int MSDS_SYNC_STAGES = 2;
   typedef enum logic [1:0] {MSDS_IDLE, MSDS_RUN, MSDS_WAIT_TR} msds_state_e;
endpackage

//--- msds_sel_if.sv
/*
 Carrier between the input front end and the start sequencer: qualified
 edges, levels and the decoded data set number.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface msds_sel_if #(parameter int SET_W = 7);
   logic seq_lvl;
   logic seq_rise;
   logic seq_fall;
   logic single_rise;
   logic confirm_rise;
   logic [SET_W-1:0] sel_num;
   modport src (output seq_lvl, seq_rise, seq_fall, single_rise, confirm_rise, sel_num);
   modport dst (input seq_lvl, seq_rise, seq_fall, single_rise, confirm_rise, sel_num);
endinterface
`default_nettype wire

//--- msds_sel.sv
/*
 Input front end: two-stage synchronisers for the start, select and data set
 bit pins, previous-cycle edge detection and bit-coded number decode.
 Assumes the assignment mask comes from logic on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module msds_sel
   import msds_pkg::*;
#(
   parameter int SET_W = MSDS_SET_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic start_seq_pin,
   input wire logic start_single_pin,
   input wire logic set_select_pin,
   input wire logic [SET_W-1:0] set_bit_pins,
   input wire logic [SET_W-1:0] set_bit_assigned,
   msds_sel_if.src sel
);
   localparam int VW = SET_W + 3;

   logic [VW-1:0] sync1_r, sync1_nxt;
   logic [VW-1:0] sync2_r, sync2_nxt;
   logic [VW-1:0] prev_r, prev_nxt;

   always_comb begin
      sync1_nxt = sync1_r;
      sync2_nxt = sync2_r;
      prev_nxt = prev_r;
      if (ce) begin
         sync1_nxt = {set_select_pin, start_single_pin, start_seq_pin, set_bit_pins};
         sync2_nxt = sync1_r;
         prev_nxt = sync2_r; // RULE17
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
         prev_r <= '0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r <= prev_nxt;
      end
   end

   // Edges compare the settled stage with the cycle before it
   assign sel.seq_lvl = sync2_r[SET_W];
   assign sel.seq_rise = sync2_r[SET_W] & ~prev_r[SET_W]; // RULE17
   assign sel.seq_fall = ~sync2_r[SET_W] & prev_r[SET_W]; // RULE17
   assign sel.single_rise = sync2_r[SET_W+1] & ~prev_r[SET_W+1];
   assign sel.confirm_rise = sync2_r[SET_W+2] & ~prev_r[SET_W+2];
   // Unassigned bits weigh zero, so an empty mask selects set 0
   assign sel.sel_num = sync2_r[SET_W-1:0] & set_bit_assigned; // RULE4 RULE5 RULE16
endmodule
`default_nettype wire

//--- msds_start.sv
/*
 Start sequencer for the motion sequence operating mode: parameter port,
 sequence and single data set starts, chaining, cancel and end status.
 Assumes a motion core that takes start_pulse/start_num, reports motion_done
 and presents the link data of the running data set.
*/
// Operation
// RULE1: A sequence data set naming a successor starts it after the movement ends.
// RULE2: With a transition condition the successor waits until that condition is met.
// RULE3: Sequence start uses the number confirmed earlier by the select input.
// RULE4: With no selection bits assigned, select confirms data set zero.
// RULE5: Selected number is the binary weighting of assigned bits from bit zero.
// RULE6: Start condition 0 rising, 1 falling, 2 high, 3 low; applied at next movement.
// RULE7: The start condition governs the first start after the mode becomes active.
// RULE8: After sequence end, 0 demands new confirmation, 1 adopts selection automatically.
// RULE9: Reselect and falling-edge settings are writable only with power stage off.
// RULE10: A single data set start never chains to a successor.
// RULE11: Rising edge on single start input starts the selected set without chaining.
// RULE12: Single starts take the selection inputs as confirmed at once.
// RULE13: Falling-edge response 0 ignores it, 1 cancels the active movement.
// RULE14: Fieldbus bit 4 rising starts a set; bit 5 picks single or sequence.
// RULE15: Status bit 10 goes high when a sequence has ended.
// RULE16: 128 data sets exist, numbered 0 to 127.
// RULE17: Inputs are sampled on the clock; edges compare with the previous cycle.
`timescale 1ns/1ps
`default_nettype none
module msds_start
   import msds_pkg::*;
#(
   parameter int SET_W = MSDS_SET_W
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic start_seq_pin,
   input wire logic start_single_pin,
   input wire logic set_select_pin,
   input wire logic [SET_W-1:0] set_bit_pins,
   input wire logic [SET_W-1:0] set_bit_assigned,
   input wire logic fieldbus_mode,
   input wire logic mode_active,
   input wire logic power_enabled,
   input wire logic [15:0] fieldbus_control_word,
   input wire logic [SET_W-1:0] fieldbus_start_set_number,
   input wire logic par_wr,
   input wire logic [15:0] par_addr,
   input wire logic [15:0] par_wdata,
   input wire logic motion_done,
   input wire logic next_valid,
   input wire logic [SET_W-1:0] next_num,
   input wire logic trans_defined,
   input wire logic trans_met,
   output logic [15:0] par_rdata,
   output logic start_pulse,
   output logic start_is_seq,
   output logic [SET_W-1:0] start_num,
   output logic cancel_move,
   output logic [15:0] fieldbus_status_word
);
   msds_sel_if #(.SET_W(SET_W)) sel ();

   msds_sel #(.SET_W(SET_W)) u_sel (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .start_seq_pin(start_seq_pin),
      .start_single_pin(start_single_pin),
      .set_select_pin(set_select_pin),
      .set_bit_pins(set_bit_pins),
      .set_bit_assigned(set_bit_assigned),
      .sel(sel.src)
   );

   ////////////////////////////////////////////////////////////////////////////
   msds_state_e state_r, state_nxt;
   logic [1:0] cond_r, cond_nxt;
   logic [1:0] cond_eff_r, cond_eff_nxt;
   logic resel_r, resel_nxt;
   logic fall_r, fall_nxt;
   logic conf_valid_r, conf_valid_nxt;
   logic [SET_W-1:0] conf_num_r, conf_num_nxt;
   logic [SET_W-1:0] pend_num_r, pend_num_nxt;
   logic seq_mode_r, seq_mode_nxt;
   logic ctrl_prev_r, ctrl_prev_nxt;
   logic [15:0] rdata_r, rdata_nxt;
   logic start_r, start_nxt;
   logic [SET_W-1:0] num_r, num_nxt;
   logic cancel_r, cancel_nxt;
   logic seq_end_r, seq_end_nxt;

   logic run_ok;
   logic local_ok;
   logic seq_trig;
   logic fb_start;
   logic cancel_req;

   assign run_ok = mode_active & power_enabled;
   assign local_ok = run_ok & ~fieldbus_mode;
   assign fb_start = run_ok & fieldbus_mode & fieldbus_control_word[MSDS_CTRL_START_BIT]
      & ~ctrl_prev_r; // RULE14
   assign cancel_req = local_ok & (fall_r == MSDS_FALL_CANCEL) & sel.seq_fall; // RULE13

   always_comb begin
      unique case (cond_eff_r) // RULE6
         MSDS_COND_RISE: seq_trig = sel.seq_rise;
         MSDS_COND_FALL: seq_trig = sel.seq_fall;
         MSDS_COND_HIGH: seq_trig = sel.seq_lvl;
         MSDS_COND_LOW: seq_trig = ~sel.seq_lvl;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      cond_nxt = cond_r;
      cond_eff_nxt = cond_eff_r;
      resel_nxt = resel_r;
      fall_nxt = fall_r;
      conf_valid_nxt = conf_valid_r;
      conf_num_nxt = conf_num_r;
      pend_num_nxt = pend_num_r;
      seq_mode_nxt = seq_mode_r;
      ctrl_prev_nxt = ctrl_prev_r;
      rdata_nxt = rdata_r;
      start_nxt = start_r & ~ce;
      num_nxt = num_r;
      cancel_nxt = cancel_r & ~ce;
      seq_end_nxt = seq_end_r;
      if (ce) begin
         ctrl_prev_nxt = fieldbus_control_word[MSDS_CTRL_START_BIT];
         if (par_wr) begin
            unique case (par_addr)
               MSDS_ADDR_COND: cond_nxt = par_wdata[1:0];
               MSDS_ADDR_RESEL: if (!power_enabled) resel_nxt = par_wdata[0]; // RULE9
               MSDS_ADDR_FALL: if (!power_enabled) fall_nxt = par_wdata[0]; // RULE9
               default: ;
            endcase
         end
         unique case (par_addr)
            MSDS_ADDR_COND: rdata_nxt = {14'h0000, cond_r};
            MSDS_ADDR_RESEL: rdata_nxt = {15'h0000, resel_r};
            MSDS_ADDR_FALL: rdata_nxt = {15'h0000, fall_r};
            default: rdata_nxt = 16'h0000;
         endcase
         if (sel.confirm_rise) begin
            conf_num_nxt = sel.sel_num; // RULE3
            conf_valid_nxt = 1'b1;
         end
         if (!run_ok) begin
            state_nxt = MSDS_IDLE;
            cond_eff_nxt = cond_r;
         end else begin
            unique case (state_r)
               MSDS_IDLE: begin
                  // Latching here keeps a new condition from acting mid-movement
                  cond_eff_nxt = cond_r; // RULE6 RULE7
                  if (fb_start) begin
                     start_nxt = 1'b1;
                     num_nxt = fieldbus_start_set_number;
                     seq_mode_nxt = fieldbus_control_word[MSDS_CTRL_SEQ_BIT]; // RULE14
                     state_nxt = MSDS_RUN;
                     seq_end_nxt = 1'b0;
                  end else if (local_ok && sel.single_rise) begin
                     start_nxt = 1'b1;
                     num_nxt = sel.sel_num; // RULE11 RULE12
                     seq_mode_nxt = 1'b0;
                     state_nxt = MSDS_RUN;
                     seq_end_nxt = 1'b0;
                  end else if (local_ok && seq_trig && conf_valid_r) begin
                     start_nxt = 1'b1;
                     num_nxt = conf_num_r; // RULE3
                     seq_mode_nxt = 1'b1;
                     state_nxt = MSDS_RUN;
                     seq_end_nxt = 1'b0;
                  end
               end
               MSDS_RUN: begin
                  if (cancel_req) begin
                     cancel_nxt = 1'b1; // RULE13
                     state_nxt = MSDS_IDLE;
                  end else if (motion_done) begin
                     if (seq_mode_r && next_valid) begin
                        pend_num_nxt = next_num;
                        if (trans_defined && !trans_met) begin
                           state_nxt = MSDS_WAIT_TR; // RULE2
                        end else begin
                           start_nxt = 1'b1; // RULE1
                           num_nxt = next_num;
                        end
                     end else begin
                        state_nxt = MSDS_IDLE; // RULE10
                        if (seq_mode_r) begin
                           seq_end_nxt = 1'b1; // RULE15
                           if (resel_r == MSDS_RESEL_AUTO) begin
                              conf_num_nxt = sel.sel_num; // RULE8
                              conf_valid_nxt = 1'b1;
                           end else if (!sel.confirm_rise) begin
                              conf_valid_nxt = 1'b0; // RULE8
                           end
                        end
                     end
                  end
               end
               MSDS_WAIT_TR: begin
                  if (cancel_req) begin
                     cancel_nxt = 1'b1;
                     state_nxt = MSDS_IDLE;
                  end else if (trans_met) begin
                     start_nxt = 1'b1; // RULE2
                     num_nxt = pend_num_r;
                     state_nxt = MSDS_RUN;
                  end
               end
               default: state_nxt = MSDS_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= MSDS_IDLE;
         cond_r <= MSDS_COND_RST;
         cond_eff_r <= MSDS_COND_RST;
         resel_r <= MSDS_RESEL_RST;
         fall_r <= MSDS_FALL_RST;
         conf_valid_r <= 1'b0;
         conf_num_r <= '0;
         pend_num_r <= '0;
         seq_mode_r <= 1'b0;
         ctrl_prev_r <= 1'b0;
         rdata_r <= 16'h0000;
         start_r <= 1'b0;
         num_r <= '0;
         cancel_r <= 1'b0;
         seq_end_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cond_r <= cond_nxt;
         cond_eff_r <= cond_eff_nxt;
         resel_r <= resel_nxt;
         fall_r <= fall_nxt;
         conf_valid_r <= conf_valid_nxt;
         conf_num_r <= conf_num_nxt;
         pend_num_r <= pend_num_nxt;
         seq_mode_r <= seq_mode_nxt;
         ctrl_prev_r <= ctrl_prev_nxt;
         rdata_r <= rdata_nxt;
         start_r <= start_nxt;
         num_r <= num_nxt;
         cancel_r <= cancel_nxt;
         seq_end_r <= seq_end_nxt;
      end
   end

   assign par_rdata = rdata_r;
   assign start_pulse = start_r;
   assign start_is_seq = seq_mode_r;
   assign start_num = num_r;
   assign cancel_move = cancel_r;
   assign fieldbus_status_word = {5'h00, seq_end_r, 10'h000};

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_CHAIN: assert property (ce && run_ok && state_r == MSDS_RUN && !cancel_req && motion_done // RULE1
      && seq_mode_r && next_valid && !(trans_defined && !trans_met)
      |=> start_pulse && start_num == $past(next_num) && state_r == MSDS_RUN)
      else $error("successor not started after movement end");
   AST_TR_WAIT: assert property (ce && run_ok && state_r == MSDS_WAIT_TR && !trans_met // RULE2
      |=> !start_pulse ##0 state_r != MSDS_RUN)
      else $error("successor started before transition condition");
   AST_SEQ_NUM: assert property (ce && local_ok && state_r == MSDS_IDLE && !fb_start // RULE3
      && !sel.single_rise && seq_trig && conf_valid_r
      |=> start_pulse && start_is_seq && start_num == $past(conf_num_r))
      else $error("sequence start did not use confirmed number");
   AST_RESEL: assert property (ce && run_ok && state_r == MSDS_RUN && !cancel_req && motion_done // RULE8
      && seq_mode_r && !next_valid && resel_r == MSDS_RESEL_CONFIRM && !sel.confirm_rise
      |=> !conf_valid_r && fieldbus_status_word[MSDS_STAT_SEQ_END_BIT])
      else $error("confirmation kept after sequence end");
   AST_LOCK: assert property (par_wr && power_enabled && par_addr == MSDS_ADDR_FALL // RULE9
      |=> fall_r == $past(fall_r))
      else $error("falling edge setting changed with power stage on");
   AST_NO_CHAIN: assert property (ce && run_ok && state_r == MSDS_RUN && !cancel_req // RULE10
      && motion_done && !seq_mode_r |=> !start_pulse && state_r == MSDS_IDLE)
      else $error("single data set chained");
   AST_SINGLE: assert property (ce && local_ok && state_r == MSDS_IDLE && !fb_start // RULE11
      && sel.single_rise |=> start_pulse && !start_is_seq && start_num == $past(sel.sel_num))
      else $error("single start wrong");
   AST_CANCEL: assert property (ce && state_r != MSDS_IDLE && cancel_req // RULE13
      |=> cancel_move && !start_pulse ##1 (!cancel_move || !$past(ce)))
      else $error("falling edge did not cancel");
   AST_FB: assert property (ce && state_r == MSDS_IDLE && fb_start // RULE14
      |=> start_pulse && start_is_seq == $past(fieldbus_control_word[MSDS_CTRL_SEQ_BIT]))
      else $error("fieldbus start wrong");
   AST_END: assert property ($rose(fieldbus_status_word[MSDS_STAT_SEQ_END_BIT]) // RULE15
      |-> $past(state_r == MSDS_RUN && motion_done && seq_mode_r))
      else $error("sequence end flag without sequence end");

   COV_SEQ_CHAIN: cover property (start_pulse && start_is_seq ##[1:50] start_pulse);
   COV_WAIT: cover property (state_r == MSDS_WAIT_TR ##[1:50] start_pulse);
   COV_CANCEL: cover property (cancel_move);
   COV_END: cover property ($rose(fieldbus_status_word[MSDS_STAT_SEQ_END_BIT]));
endmodule
`default_nettype wire

//--- msds_ctrl_model.sv
/*
 Controller model: drives the start, select and data set bit pins.
 Assumes the bench calls its tasks from one process, between rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module msds_ctrl_model
   import msds_pkg::*;
(
   input wire logic mclk,
   output logic start_seq_pin,
   output logic start_single_pin,
   output logic set_select_pin,
   output logic [MSDS_SET_W-1:0] set_bit_pins
);
   initial begin
      start_seq_pin = 1'b0;
      start_single_pin = 1'b0;
      set_select_pin = 1'b0;
      set_bit_pins = 7'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // set_num and confirm hold levels past the two-stage synchroniser; seq_lvl and single_lvl return at once
   task automatic set_num(input logic [MSDS_SET_W-1:0] n);
      @(negedge mclk);
      set_bit_pins = n;
      repeat (4) @(negedge mclk);
   endtask
   task automatic confirm();
      @(negedge mclk);
      set_select_pin = 1'b1;
      repeat (4) @(negedge mclk);
      set_select_pin = 1'b0;
      repeat (4) @(negedge mclk);
   endtask
   task automatic seq_lvl(input logic v);
      @(negedge mclk);
      start_seq_pin = v;
   endtask
   task automatic single_lvl(input logic v);
      @(negedge mclk);
      start_single_pin = v;
   endtask
endmodule
`default_nettype wire

//--- msds_start_bench.sv
/*
 Self-checking bench for the start sequencer: parameter port, local and
 fieldbus starts, chaining, transitions, end status and cancel.
 Assumes msds_pkg and the controller model; the bench plays the motion core.
*/
`timescale 1ns/1ps
`default_nettype none
module msds_start_bench
   import msds_pkg::*;
;
   logic mclk, rst_n, ce, fieldbus_mode, mode_active, power_enabled, par_wr;
   logic motion_done, next_valid, trans_defined, trans_met;
   logic start_pulse, start_is_seq, cancel_move;
   logic start_seq_pin, start_single_pin, set_select_pin;
   logic [MSDS_SET_W-1:0] set_bit_pins, set_bit_assigned, next_num;
   logic [MSDS_SET_W-1:0] fieldbus_start_set_number, start_num;
   logic [15:0] fieldbus_control_word, par_addr, par_wdata, par_rdata;
   logic [15:0] fieldbus_status_word;
   int error_cnt = 0;
   int tests_run = 0;
   int cancel_cnt = 0;
   int cyc = 0;

   msds_ctrl_model u_msds_ctrl_model (
      .mclk(mclk),
      .start_seq_pin(start_seq_pin),
      .start_single_pin(start_single_pin),
      .set_select_pin(set_select_pin),
      .set_bit_pins(set_bit_pins)
   );
   msds_start u_msds_start (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .start_seq_pin(start_seq_pin),
      .start_single_pin(start_single_pin),
      .set_select_pin(set_select_pin),
      .set_bit_pins(set_bit_pins),
      .set_bit_assigned(set_bit_assigned),
      .fieldbus_mode(fieldbus_mode),
      .mode_active(mode_active),
      .power_enabled(power_enabled),
      .fieldbus_control_word(fieldbus_control_word),
      .fieldbus_start_set_number(fieldbus_start_set_number),
      .par_wr(par_wr),
      .par_addr(par_addr),
      .par_wdata(par_wdata),
      .motion_done(motion_done),
      .next_valid(next_valid),
      .next_num(next_num),
      .trans_defined(trans_defined),
      .trans_met(trans_met),
      .par_rdata(par_rdata),
      .start_pulse(start_pulse),
      .start_is_seq(start_is_seq),
      .start_num(start_num),
      .cancel_move(cancel_move),
      .fieldbus_status_word(fieldbus_status_word)
   );

   initial mclk = 1'b0;
   always #50 mclk = ~mclk;
   // Run is a few hundred cycles at most; the ceiling only catches a hang
   // Sampled on the falling edge, where registered outputs have settled
   always @(negedge mclk) begin
      cyc++;
      if (cancel_move === 1'b1) cancel_cnt++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic par_write(input logic [15:0] a, input logic [15:0] d);
      @(negedge mclk);
      par_wr = 1'b1;
      par_addr = a;
      par_wdata = d;
      @(negedge mclk);
      par_wr = 1'b0;
   endtask
   task automatic par_read(input logic [15:0] a, input logic [15:0] exp);
      @(negedge mclk);
      par_addr = a;
      repeat (3) @(negedge mclk);
      chk(par_rdata, exp);
   endtask
   // Motion core ends the movement; the next wait task drops the pulse
   task automatic end_move(input logic nv, input logic [MSDS_SET_W-1:0] nn,
                           input logic td);
      @(negedge mclk);
      motion_done = 1'b1;
      next_valid = nv;
      next_num = nn;
      trans_defined = td;
   endtask
   task automatic expect_start(input logic [MSDS_SET_W-1:0] num, input logic seq);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 10 && !hit; i++) begin
         @(negedge mclk);
         motion_done = 1'b0;
         hit = (start_pulse === 1'b1);
      end
      chk(16'(hit), 16'h0001);
      chk(16'(start_num), 16'(num));
      chk(16'(start_is_seq), 16'(seq));
   endtask
   task automatic expect_none(input int n);
      int hits;
      hits = 0;
      repeat (n) begin
         @(negedge mclk);
         motion_done = 1'b0;
         if (start_pulse !== 1'b0) hits++;
      end
      chk(16'(hits), 16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      set_bit_assigned = 7'h7f;
      fieldbus_mode = 1'b0;
      mode_active = 1'b1;
      power_enabled = 1'b1;
      fieldbus_control_word = 16'h0000;
      fieldbus_start_set_number = 7'h00;
      par_wr = 1'b0;
      par_addr = 16'h0000;
      par_wdata = 16'h0000;
      motion_done = 1'b0;
      next_valid = 1'b0;
      next_num = 7'h00;
      trans_defined = 1'b0;
      trans_met = 1'b0;
      repeat (10) @(negedge mclk);
      rst_n = 1'b1;
      par_read(MSDS_ADDR_COND, 16'h0000);
      par_read(MSDS_ADDR_RESEL, 16'h0000);
      par_read(MSDS_ADDR_FALL, 16'h0000);
      par_write(MSDS_ADDR_RESEL, 16'h0001);
      par_read(MSDS_ADDR_RESEL, 16'h0000);
      par_write(MSDS_ADDR_FALL, 16'h0001);
      par_read(MSDS_ADDR_FALL, 16'h0000);
      par_write(16'h2d14, 16'hffff);
      par_read(16'h2d14, 16'h0000);
      // Single start at the top data set number never chains
      u_msds_ctrl_model.set_num(7'h7f);
      u_msds_ctrl_model.single_lvl(1'b1);
      expect_start(7'h7f, 1'b0);
      u_msds_ctrl_model.single_lvl(1'b0);
      end_move(1'b1, 7'h05, 1'b0);
      expect_none(8);
      u_msds_ctrl_model.seq_lvl(1'b1);
      expect_none(8);
      u_msds_ctrl_model.seq_lvl(1'b0);
      // Sequence with partial mask, chaining, transition wait and end status
      set_bit_assigned = 7'h0f;
      u_msds_ctrl_model.set_num(7'h3a);
      u_msds_ctrl_model.confirm();
      u_msds_ctrl_model.seq_lvl(1'b1);
      expect_start(7'h0a, 1'b1);
      end_move(1'b1, 7'h09, 1'b0);
      expect_start(7'h09, 1'b1);
      end_move(1'b1, 7'h11, 1'b1);
      expect_none(6);
      trans_met = 1'b1;
      expect_start(7'h11, 1'b1);
      trans_met = 1'b0;
      end_move(1'b0, 7'h00, 1'b0);
      expect_none(3);
      chk(fieldbus_status_word, 16'h0400);
      u_msds_ctrl_model.seq_lvl(1'b0);
      u_msds_ctrl_model.seq_lvl(1'b1);
      expect_none(8);
      u_msds_ctrl_model.seq_lvl(1'b0);
      set_bit_assigned = 7'h00;
      u_msds_ctrl_model.confirm();
      u_msds_ctrl_model.seq_lvl(1'b1);
      expect_start(7'h00, 1'b1);
      u_msds_ctrl_model.seq_lvl(1'b0);
      end_move(1'b0, 7'h00, 1'b0);
      expect_none(4);
      chk(16'(cancel_cnt), 16'h0000);
      // Automatic reselection after the end of a sequence
      power_enabled = 1'b0;
      par_write(MSDS_ADDR_RESEL, 16'h0001);
      par_read(MSDS_ADDR_RESEL, 16'h0001);
      power_enabled = 1'b1;
      set_bit_assigned = 7'h7f;
      u_msds_ctrl_model.set_num(7'h21);
      u_msds_ctrl_model.confirm();
      u_msds_ctrl_model.seq_lvl(1'b1);
      expect_start(7'h21, 1'b1);
      end_move(1'b0, 7'h00, 1'b0);
      expect_none(3);
      u_msds_ctrl_model.seq_lvl(1'b0);
      u_msds_ctrl_model.seq_lvl(1'b1);
      expect_start(7'h21, 1'b1);
      u_msds_ctrl_model.seq_lvl(1'b0);
      end_move(1'b0, 7'h00, 1'b0);
      expect_none(3);
      // Every start condition, each armed while the mode is inactive
      for (int c = 0; c < 4; c++) begin
         mode_active = 1'b0;
         par_write(MSDS_ADDR_COND, 16'(c));
         par_read(MSDS_ADDR_COND, 16'(c));
         u_msds_ctrl_model.seq_lvl(c[0]);
         mode_active = 1'b1;
         u_msds_ctrl_model.confirm();
         expect_none(4);
         u_msds_ctrl_model.seq_lvl(~c[0]);
         expect_start(7'h21, 1'b1);
         end_move(1'b0, 7'h00, 1'b0);
         expect_none(1);
      end
      // Falling start edge cancels the running movement
      mode_active = 1'b0;
      power_enabled = 1'b0;
      par_write(MSDS_ADDR_FALL, 16'h0001);
      par_write(MSDS_ADDR_COND, 16'h0000);
      par_read(MSDS_ADDR_FALL, 16'h0001);
      u_msds_ctrl_model.seq_lvl(1'b0);
      power_enabled = 1'b1;
      mode_active = 1'b1;
      u_msds_ctrl_model.confirm();
      u_msds_ctrl_model.seq_lvl(1'b1);
      expect_start(7'h21, 1'b1);
      u_msds_ctrl_model.seq_lvl(1'b0);
      expect_none(8);
      chk(16'(cancel_cnt), 16'h0001);
      chk(fieldbus_status_word, 16'h0000);
      // Fieldbus starts, sequence then single
      fieldbus_mode = 1'b1;
      fieldbus_start_set_number = 7'h44;
      fieldbus_control_word = 16'h0020;
      expect_none(2);
      fieldbus_control_word = 16'h0030;
      expect_start(7'h44, 1'b1);
      end_move(1'b0, 7'h00, 1'b0);
      expect_none(2);
      fieldbus_control_word = 16'h0000;
      fieldbus_start_set_number = 7'h13;
      expect_none(2);
      fieldbus_control_word = 16'h0010;
      expect_start(7'h13, 1'b0);
      // Clock enable low freezes everything, the start pulse included
      ce = 1'b0;
      fieldbus_control_word = 16'h0000;
      repeat (3) @(negedge mclk);
      chk(16'(start_pulse), 16'h0001);
      chk(16'(start_num), 16'h0013);
      ce = 1'b1;
      expect_none(2);
      // Reset in mid-run clears outputs and settings
      power_enabled = 1'b0;
      par_write(MSDS_ADDR_FALL, 16'h0001);
      rst_n = 1'b0;
      @(negedge mclk);
      chk(16'(start_num), 16'h0000);
      chk(16'(start_is_seq), 16'h0000);
      rst_n = 1'b1;
      power_enabled = 1'b1;
      par_read(MSDS_ADDR_FALL, 16'h0000);
      print_verdict();
   end
endmodule
`default_nettype wire
